// *** rtl/mpf_pause_ctl.sv ***
// Behaviour
// - Every transmitted pause frame carries the programmed pause time in its time field.
// - With pass-control set and flow control on in full duplex, a valid received pause frame gets its packet-filter bit set.
// - With pass-control clear and flow control on in full duplex, a valid received pause frame gets its packet-filter bit cleared.
// - Every received frame is forwarded to the application, good, bad or control.
// - Promiscuous filtering overrides the pass-control setting in the status.
// - With flow control on in full duplex, a valid pause holds the transmitter for time x slot.
// - With flow control off, frames are not inspected and no pause takes effect.
// - In half duplex the enable bit together with the backpressure request bit turns on backpressure instead.
// - The busy flag is high while a pause frame or backpressure is being sent.
// - The busy flag returns to zero when the pause frame has been sent.
// - With the transmitter disabled, no pause frame and no backpressure go out.
`default_nettype none
module mpf_pause_ctl #(
  parameter int          SLOT_CYC_10M = mpf_pkg::SLOT_CYC_10,
  parameter logic [47:0] STATION_ADDR = 48'h0000_0000_0000
) (
  input  wire logic                   core_clk,
  input  wire logic                   arst_n,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   full_duplex,
  input  wire logic                   tx_enable,
  input  wire logic                   speed_100,
  input  wire logic                   promiscuous,
  input  wire logic                   addr_pass,
  input  wire logic                   rx_valid,
  input  wire mpf_pkg::mpf_rx_beat_t  rx_beat,
  output logic                        app_valid,
  output mpf_pkg::mpf_rx_beat_t       app_beat,
  output logic                        app_status_valid,
  output mpf_pkg::mpf_rx_status_t     app_status,
  output logic                        tx_valid,
  output mpf_pkg::mpf_tx_beat_t       tx_beat,
  input  wire logic                   tx_ready,
  output logic                        tx_hold,
  output logic                        backpressure
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } mpf_tx_state_t;

  mpf_tx_state_t        state;
  logic [15:0]          pause_time;
  logic                 pass_ctl;
  logic                 fc_en;
  logic                 send_req;
  logic                 bp_req;
  logic                 bp_active;
  logic                 busy;
  logic [15:0]          sent_time;
  logic [5:0]           idx;
  logic                 start;
  logic                 take;
  logic                 ap_valid;
  logic                 ap_wr;
  logic [11:0]          ap_addr;
  logic                 rd_stage;
  logic                 wr_flow;
  logic                 wr_ctrl;
  logic [31:0]          rd_word;
  logic                 addr_pass_q;
  logic                 dec_valid;
  mpf_pkg::mpf_decode_t dec;

  // Bus slave: writes take no wait, reads one wait so a write just before is seen
  assign take      = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_stage;
  assign hresp     = 1'b0;
  assign wr_flow   = ap_valid & ap_wr & (ap_addr == mpf_pkg::FLOW_ADDR);
  assign wr_ctrl   = ap_valid & ap_wr & (ap_addr == mpf_pkg::CTRL_ADDR);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ap_valid <= 1'b0;
      ap_wr    <= 1'b0;
      ap_addr  <= 12'h000;
      rd_stage <= 1'b0;
    end else begin
      ap_valid <= take;
      rd_stage <= take & ~hwrite;
      if (take) begin
        ap_wr   <= hwrite;
        ap_addr <= haddr[11:0];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (ap_addr == mpf_pkg::FLOW_ADDR) begin
      rd_word[31:mpf_pkg::TIME_LSB] = pause_time;
      rd_word[mpf_pkg::PASS_BIT]    = pass_ctl;
      rd_word[mpf_pkg::EN_BIT]      = fc_en;
      rd_word[mpf_pkg::BUSY_BIT]    = busy;
    end else if (ap_addr == mpf_pkg::CTRL_ADDR) begin
      rd_word[mpf_pkg::SEND_BIT] = send_req;
      rd_word[mpf_pkg::BP_BIT]   = bp_req;
      rd_word[mpf_pkg::HOLD_BIT] = tx_hold;
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_stage) begin
      hrdata <= rd_word;
    end
  end

  // Busy bit is status only; whatever is written there is dropped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pause_time <= mpf_pkg::FLOW_RST[31:16];
      pass_ctl   <= mpf_pkg::FLOW_RST[mpf_pkg::PASS_BIT];
      fc_en      <= mpf_pkg::FLOW_RST[mpf_pkg::EN_BIT];
    end else if (wr_flow) begin
      pause_time <= hwdata[31:mpf_pkg::TIME_LSB];
      pass_ctl   <= hwdata[mpf_pkg::PASS_BIT];
      fc_en      <= hwdata[mpf_pkg::EN_BIT];
    end
  end

  // Software request wins over the hardware clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      send_req <= mpf_pkg::CTRL_RST[mpf_pkg::SEND_BIT];
      bp_req   <= mpf_pkg::CTRL_RST[mpf_pkg::BP_BIT];
    end else begin
      if (wr_ctrl && hwdata[mpf_pkg::SEND_BIT]) begin
        send_req <= 1'b1;
      end else if (start) begin
        send_req <= 1'b0;
      end
      if (wr_ctrl) begin
        bp_req <= hwdata[mpf_pkg::BP_BIT];
      end
    end
  end

  // Pause frame is only sent in full duplex with the transmitter on
  assign start = (state == TX_IDLE) & send_req & full_duplex & tx_enable;

  function automatic logic [7:0] frame_byte(input logic [5:0] i, input logic [15:0] t);
    logic [7:0] b;
    b = 8'h00;
    if (i < mpf_pkg::DA_LEN) begin
      b = mpf_pkg::PAUSE_DA[8*(5-int'(i)) +: 8];
    end else if (i < mpf_pkg::SA_END) begin
      b = STATION_ADDR[8*(11-int'(i)) +: 8];
    end else if (i == mpf_pkg::TYPE_POS) begin
      b = mpf_pkg::CTL_TYPE[15:8];
    end else if (i == mpf_pkg::TYPE_POS + 6'h01) begin
      b = mpf_pkg::CTL_TYPE[7:0];
    end else if (i == mpf_pkg::OPC_POS) begin
      b = mpf_pkg::PAUSE_OPC[15:8];
    end else if (i == mpf_pkg::OPC_POS + 6'h01) begin
      b = mpf_pkg::PAUSE_OPC[7:0];
    end else if (i == mpf_pkg::TIME_POS) begin
      b = t[15:8];
    end else if (i == mpf_pkg::TIME_POS + 6'h01) begin
      b = t[7:0];
    end
    return b;
  endfunction

  // Time is latched at frame start, a late register write cannot tear the frame
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= TX_IDLE;
      idx       <= 6'h00;
      sent_time <= 16'h0000;
      tx_beat   <= '0;
    end else begin
      unique case (state)
        TX_IDLE: begin
          if (start) begin
            state        <= TX_SEND;
            idx          <= 6'h00;
            sent_time    <= pause_time;
            tx_beat.data <= frame_byte(6'h00, pause_time);
            tx_beat.last <= 1'b0;
          end
        end
        TX_SEND: begin
          if (tx_ready) begin
            if (tx_beat.last) begin
              state <= TX_IDLE;
            end else begin
              idx          <= idx + 6'h01;
              tx_beat.data <= frame_byte(idx + 6'h01, sent_time);
              tx_beat.last <= (idx + 6'h01) == mpf_pkg::FRAME_LAST;
            end
          end
        end
      endcase
    end
  end

  assign tx_valid = state == TX_SEND;

  // Half duplex uses the enable bit for backpressure
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bp_active <= 1'b0;
    end else begin
      bp_active <= ~full_duplex & fc_en & tx_enable & bp_req;
    end
  end

  assign backpressure = bp_active;
  assign busy         = (state == TX_SEND) | bp_active;

  mpf_ctl_decoder u_dec (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .en           (fc_en & full_duplex),
    .beat_valid   (rx_valid),
    .beat         (rx_beat),
    .result_valid (dec_valid),
    .result       (dec)
  );

  mpf_pause_timer #(
    .SLOT_CYC_10M (SLOT_CYC_10M)
  ) u_timer (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .load      (dec_valid & dec.hit),
    .value     (dec.time_val),
    .speed_100 (speed_100),
    .active    (tx_hold)
  );

  // Data is never dropped here; keep or discard is the application's call
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      app_valid <= 1'b0;
      app_beat  <= '0;
    end else begin
      app_valid <= rx_valid;
      app_beat  <= rx_beat;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_pass_q <= 1'b0;
    end else if (rx_valid && rx_beat.eof) begin
      addr_pass_q <= addr_pass;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      app_status_valid <= 1'b0;
      app_status       <= '0;
    end else begin
      app_status_valid     <= dec_valid;
      app_status.ctl_frame <= dec.ctl;
      app_status.pause     <= dec.hit;
      app_status.err       <= dec.err;
      if (promiscuous) begin
        app_status.pkt_filter <= 1'b1;
      end else if (dec.hit) begin
        app_status.pkt_filter <= pass_ctl;
      end else begin
        app_status.pkt_filter <= addr_pass_q;
      end
    end
  end

  sequence s_frame_start;
    (state == TX_IDLE) && start ##1 tx_valid;
  endsequence

  sequence s_last_taken;
    tx_valid && tx_ready && tx_beat.last;
  endsequence

  property p_fwd;
    rx_valid |=> app_valid && app_beat == $past(rx_beat);
  endproperty
  a_fwd: assert property (p_fwd) else $error("frame beat not forwarded");

  property p_pf_set;
    dec_valid && dec.hit && pass_ctl && !promiscuous |=> app_status.pkt_filter;
  endproperty
  a_pf_set: assert property (p_pf_set) else $error("filter bit not set on pause");

  property p_pf_clr;
    dec_valid && dec.hit && !pass_ctl && !promiscuous |=> !app_status.pkt_filter;
  endproperty
  a_pf_clr: assert property (p_pf_clr) else $error("filter bit not cleared on pause");

  property p_promisc;
    dec_valid && promiscuous |=> app_status_valid && app_status.pkt_filter;
  endproperty
  a_promisc: assert property (p_promisc) else $error("promiscuous not taking precedence");

  property p_time_field;
    tx_valid && idx == mpf_pkg::TIME_POS |-> tx_beat.data == pause_time[15:8];
  endproperty
  a_time_field: assert property (p_time_field) else $error("wrong pause time byte");

  property p_busy_frame;
    s_frame_start |-> busy ##1 busy;
  endproperty
  a_busy_frame: assert property (p_busy_frame) else $error("busy low during frame");

  property p_busy_clear;
    s_last_taken ##0 !bp_active ##1 !bp_active |-> !busy;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy stuck after frame");

  property p_pause_hold;
    dec_valid && dec.hit && dec.time_val != 16'h0000 |=> tx_hold [*2];
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause did not hold");

  property p_bp_on;
    !full_duplex && fc_en && tx_enable && bp_req |=> backpressure;
  endproperty
  a_bp_on: assert property (p_bp_on) else $error("backpressure missing");

  property p_tx_off;
    !tx_enable |=> !backpressure && !$rose(tx_valid);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("flow control sent while tx off");
endmodule
`default_nettype wire

// *** rtl/mpf_pkg.sv ***
`default_nettype none
package mpf_pkg;
  // Register index and byte address (index times four)
  localparam logic [9:0]  FLOW_IDX       = 10'h008;
  localparam logic [9:0]  CTRL_IDX       = 10'h010;
  localparam logic [11:0] FLOW_ADDR      = {FLOW_IDX, 2'b00};
  localparam logic [11:0] CTRL_ADDR      = {CTRL_IDX, 2'b00};
  localparam logic [31:0] FLOW_RST       = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  // Field positions
  localparam int          TIME_LSB       = 16;
  localparam int          PASS_BIT       = 2;
  localparam int          EN_BIT         = 1;
  localparam int          BUSY_BIT       = 0;
  localparam int          SEND_BIT       = 0;
  localparam int          BP_BIT         = 1;
  localparam int          HOLD_BIT       = 8;
  // Timing
  localparam int          CLK_NS         = 10;
  localparam int          SLOT_BITS      = 512;
  localparam int          BIT_NS_100     = 10;
  localparam int          BIT_NS_10      = 100;
  localparam int          SLOT_CYC_100   = SLOT_BITS * BIT_NS_100 / CLK_NS;
  localparam int          SLOT_CYC_10    = SLOT_BITS * BIT_NS_10 / CLK_NS;
  // Control frame layout, byte positions from the first destination byte
  localparam logic [5:0]  DA_LEN         = 6'h06;
  localparam logic [5:0]  SA_END         = 6'h0C;
  localparam logic [5:0]  TYPE_POS       = 6'h0C;
  localparam logic [5:0]  OPC_POS        = 6'h0E;
  localparam logic [5:0]  TIME_POS       = 6'h10;
  localparam logic [5:0]  FRAME_LAST     = 6'h3B;
  localparam logic [47:0] PAUSE_DA       = 48'h0180_C200_0001;
  localparam logic [15:0] CTL_TYPE       = 16'h8808;
  localparam logic [15:0] PAUSE_OPC      = 16'h0001;

  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eof;
    logic       err;
  } mpf_rx_beat_t;

  typedef struct packed {
    logic pkt_filter;
    logic ctl_frame;
    logic pause;
    logic err;
  } mpf_rx_status_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } mpf_tx_beat_t;

  typedef struct packed {
    logic        hit;
    logic        ctl;
    logic        err;
    logic [15:0] time_val;
  } mpf_decode_t;
endpackage
`default_nettype wire

// *** rtl/mpf_ctl_decoder.sv ***
`default_nettype none
module mpf_ctl_decoder (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  en,
  input  wire logic                  beat_valid,
  input  wire mpf_pkg::mpf_rx_beat_t beat,
  output logic                       result_valid,
  output mpf_pkg::mpf_decode_t       result
);
  logic [5:0]  pos;
  logic [5:0]  cur;
  logic        da_ok;
  logic        ty_ok;
  logic        op_ok;
  logic [15:0] time_val;
  logic        next_da_ok;
  logic        next_ty_ok;
  logic        next_op_ok;
  logic [15:0] next_time;

  always_comb begin
    cur        = beat.sof ? 6'h00 : pos;
    next_da_ok = beat.sof | da_ok;
    next_ty_ok = beat.sof | ty_ok;
    next_op_ok = beat.sof | op_ok;
    next_time  = time_val;
    if (cur < mpf_pkg::DA_LEN) begin
      next_da_ok &= beat.data == mpf_pkg::PAUSE_DA[8*(5-int'(cur)) +: 8];
    end
    if (cur == mpf_pkg::TYPE_POS) next_ty_ok &= beat.data == mpf_pkg::CTL_TYPE[15:8];
    if (cur == mpf_pkg::TYPE_POS + 6'h01) next_ty_ok &= beat.data == mpf_pkg::CTL_TYPE[7:0];
    if (cur == mpf_pkg::OPC_POS) next_op_ok &= beat.data == mpf_pkg::PAUSE_OPC[15:8];
    if (cur == mpf_pkg::OPC_POS + 6'h01) next_op_ok &= beat.data == mpf_pkg::PAUSE_OPC[7:0];
    if (cur == mpf_pkg::TIME_POS) next_time[15:8] = beat.data;
    if (cur == mpf_pkg::TIME_POS + 6'h01) next_time[7:0] = beat.data;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos      <= 6'h00;
      da_ok    <= 1'b0;
      ty_ok    <= 1'b0;
      op_ok    <= 1'b0;
      time_val <= 16'h0000;
    end else if (beat_valid) begin
      pos      <= beat.eof ? 6'h00 : (cur == 6'h3F ? cur : cur + 6'h01);
      da_ok    <= next_da_ok;
      ty_ok    <= next_ty_ok;
      op_ok    <= next_op_ok;
      time_val <= next_time;
    end
  end

  // Nothing is classified while disabled, so no pause can follow
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_valid <= 1'b0;
      result       <= '0;
    end else begin
      result_valid    <= beat_valid & beat.eof;
      result.ctl      <= en & next_ty_ok & (cur > mpf_pkg::TYPE_POS);
      result.hit      <= en & next_da_ok & next_ty_ok & next_op_ok & ~beat.err
                         & (cur > mpf_pkg::TIME_POS);
      result.err      <= beat.err;
      result.time_val <= next_time;
    end
  end

  property p_no_decode_off;
    @(posedge core_clk) disable iff (!arst_n)
    beat_valid && beat.eof && !en |=> result_valid && !result.hit && !result.ctl;
  endproperty
  a_no_decode_off: assert property (p_no_decode_off) else $error("decode while disabled");
endmodule
`default_nettype wire

// *** rtl/mpf_pause_timer.sv ***
`default_nettype none
module mpf_pause_timer #(
  parameter int SLOT_CYC_10M = mpf_pkg::SLOT_CYC_10
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        load,
  input  wire logic [15:0] value,
  input  wire logic        speed_100,
  output logic             active
);
  logic [15:0] quanta;
  logic [12:0] slot;
  logic [12:0] slot_top;

  // Slot is 512 bit times at the present link rate
  assign slot_top = speed_100 ? 13'(mpf_pkg::SLOT_CYC_100 - 1) : 13'(SLOT_CYC_10M - 1);

  // A new pause replaces the remaining time, zero cancels the hold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      quanta <= 16'h0000;
      slot   <= 13'h0000;
    end else if (load) begin
      quanta <= value;
      slot   <= slot_top;
    end else if (quanta != 16'h0000) begin
      if (slot == 13'h0000) begin
        quanta <= quanta - 16'h0001;
        slot   <= slot_top;
      end else begin
        slot <= slot - 13'h0001;
      end
    end
  end

  assign active = quanta != 16'h0000;

  logic [31:0] run_cnt;
  logic [31:0] exp_len;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= 32'h0000_0000;
      exp_len <= 32'h0000_0000;
    end else if (load) begin
      run_cnt <= 32'h0000_0000;
      exp_len <= 32'(value) * (32'(slot_top) + 32'h0000_0001);
    end else if (active) begin
      run_cnt <= run_cnt + 32'h0000_0001;
    end
  end

  property p_hold_len;
    @(posedge core_clk) disable iff (!arst_n)
    $fell(active) && !$past(load) && $stable(speed_100) |-> run_cnt == exp_len;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold length not quanta x slot");
endmodule
`default_nettype wire

// *** verif/mpf_link_partner.sv ***
`default_nettype none
module mpf_link_partner (
  input  wire logic                  core_clk,
  input  wire logic                  stall,
  input  wire logic                  tx_valid,
  input  wire mpf_pkg::mpf_tx_beat_t tx_beat,
  output logic                       tx_ready,
  output logic                       rx_valid,
  output mpf_pkg::mpf_rx_beat_t      rx_beat,
  output logic                       got,
  output mpf_pkg::mpf_tx_beat_t      got_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_beat  = '0;
    got      = 1'b0;
    got_beat = '0;
  end
  // Pause frame byte; station bytes zero, bad turns the opcode
  function automatic logic [7:0] frame_byte(input int i, input logic [15:0] t, input logic bad);
    logic [0:17][7:0] hdr;
    hdr = {mpf_pkg::PAUSE_DA, 48'h0, mpf_pkg::CTL_TYPE,
           bad ? 16'h0002 : mpf_pkg::PAUSE_OPC, t};
    return (i < 18) ? hdr[i] : 8'h00;
  endfunction
  // Accepts at random pace, records each taken byte
  always @(posedge core_clk) begin
    got      <= tx_valid & tx_ready;
    got_beat <= tx_beat;
    tx_ready <= !stall;
  end
  task automatic send_frame(input logic [15:0] t, input logic bad);
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_beat  <= '{data: frame_byte(i, t, bad), sof: i == 0, eof: i == 59, err: 1'b0};
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    // Idle line shows no stale byte
    rx_beat  <= '{data: ~rx_beat.data, sof: 1'b0, eof: 1'b0, err: 1'b0};
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CFG [4] = '{16'h0002, 16'h0002, 16'h0004, 16'h0006};
  // Status notes are {pkt_filter, ctl_frame, pause, err}
  localparam logic [3:0]  EXP_ST [4] = '{4'h6, 4'hE, 4'h8, 4'h4};
  // Nonzero station bytes so a swapped source address shows up
  localparam logic [47:0] OWN_ADDR = 48'h0A1B_2C3D_4E5F;
  logic core_clk, arst_n, hsel, hwrite, hreadyout, rdy_s, stall, got, saw_hold;
  logic full_duplex, tx_enable, speed_100, promiscuous, addr_pass, rx_valid;
  logic app_valid, app_status_valid, tx_valid, tx_ready, tx_hold, backpressure;
  logic [31:0] haddr, hwdata, hrdata, rd_s, rd, seed, rnd, rnd_s;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] pt;
  mpf_pkg::mpf_rx_beat_t   rx_beat, app_beat, rx_prev;
  mpf_pkg::mpf_rx_status_t app_status;
  mpf_pkg::mpf_tx_beat_t   tx_beat, got_beat;
  logic [8:0] tx_q[$];
  logic [3:0] stat_q[$];
  int n_fail, checks_done, n_app, n0;

  mpf_pause_ctl #(.SLOT_CYC_10M(8), .STATION_ADDR(OWN_ADDR)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .full_duplex(full_duplex), .tx_enable(tx_enable),
    .speed_100(speed_100), .promiscuous(promiscuous), .addr_pass(addr_pass),
    .rx_valid(rx_valid), .rx_beat(rx_beat), .app_valid(app_valid), .app_beat(app_beat),
    .app_status_valid(app_status_valid), .app_status(app_status), .tx_valid(tx_valid),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .tx_hold(tx_hold), .backpressure(backpressure));
  mpf_link_partner lp (
    .core_clk(core_clk), .stall(stall), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_beat(rx_beat), .got(got),
    .got_beat(got_beat));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Settled copies, taken mid-cycle to stay clear of the edge
  always @(negedge core_clk) begin
    rdy_s = hreadyout;
    rd_s  = hrdata;
  end
  always @(posedge core_clk) begin
    rnd_s = $random(seed);
    stall <= rnd_s[0];
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge core_clk); while (rdy_s !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (rdy_s !== 1'b1);
    rd = rd_s;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic hold_chk(input int exp);
    int n;
    n = 0;
    while (tx_hold !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (tx_hold === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n), 32'(exp));
  endtask

  // Result watcher: oldest note against each result
  always @(posedge core_clk) begin
    if (got) begin
      if (tx_q.size() > 0) chk({23'h0, got_beat}, {23'h0, tx_q.pop_front()});
      else chk({23'h0, got_beat}, 32'hFFFF_FFFF);
    end
    if (app_status_valid) begin
      chk({28'h0, app_status}, {28'h0, stat_q.pop_front()});
    end
    if (app_valid) chk({21'h0, app_beat}, {21'h0, rx_prev});
    rx_prev = rx_beat;
    if (app_valid) n_app++;
    if (tx_hold) saw_hold = 1'b1;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    seed = 32'h287C118C;
    {arst_n, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {full_duplex, tx_enable, speed_100, promiscuous, addr_pass, stall} = 6'b100000;
    hsize = 3'h2;
    rnd = $random(seed);
    pt = rnd[15:0];
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    rd_chk(12'h020, 32'h0);
    rd_chk(12'h040, 32'h0);
    bus(1'b1, 12'h03C, 32'hFFFF_FFFF);
    rd_chk(12'h03C, 32'h0);
    bus(1'b1, 12'h020, {pt, 16'h0004});
    bus(1'b1, 12'h020, {pt, 16'h0006});
    rd_chk(12'h020, {pt, 16'h0006});
    $display("test registers done");
    bus(1'b1, 12'h040, 32'h1);
    repeat (80) @(posedge core_clk);
    rd_chk(12'h040, 32'h1);
    for (int i = 0; i < 60; i++) begin
      logic [7:0] b;
      b = (i > 5 && i < 12) ? OWN_ADDR[8*(11-i) +: 8] : lp.frame_byte(i, pt, 1'b0);
      tx_q.push_back({b, i == 59});
    end
    tx_enable <= 1'b1;
    rd_chk(12'h020, {pt, 16'h0007});
    for (int i = 0; i < 400 && tx_q.size() > 0; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk(32'(tx_q.size()), 32'h0);
    rd_chk(12'h020, {pt, 16'h0006});
    $display("test pause send done");
    stat_q.push_back(4'hE);
    n0 = n_app;
    lp.send_frame(16'h0003, 1'b0);
    hold_chk(24);
    chk(32'(n_app - n0), 32'd60);
    speed_100 <= 1'b1;
    stat_q.push_back(4'hE);
    lp.send_frame(16'h0001, 1'b0);
    hold_chk(512);
    speed_100 <= 1'b0;
    $display("test pause receive done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 12'h020, {pt, CFG[k]});
      promiscuous <= k == 1;
      addr_pass <= k == 2;
      stat_q.push_back(EXP_ST[k]);
      saw_hold = 1'b0;
      lp.send_frame(16'h0002, k == 3);
      repeat (30) @(posedge core_clk);
      chk({31'h0, saw_hold}, {31'h0, k < 2});
    end
    $display("test status done");
    full_duplex <= 1'b0;
    bus(1'b1, 12'h020, {pt, 16'h0002});
    bus(1'b1, 12'h040, 32'h2);
    repeat (3) @(posedge core_clk);
    chk({31'h0, backpressure}, 32'h1);
    rd_chk(12'h020, {pt, 16'h0003});
    tx_enable <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, backpressure}, 32'h0);
    // Busy must read clear before the flow register is written
    rd_chk(12'h020, {pt, 16'h0002});
    bus(1'b1, 12'h020, {pt, 16'h0000});
    tx_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({31'h0, backpressure}, 32'h0);
    $display("test backpressure done");
    report_and_stop();
  end
endmodule
`default_nettype wire
